// file: ppp_pkg.sv
// Purpose: Shared constants for the parallel programming port.
// Assumes: A 250 MHz system clock.
// Notes: Command codes, action codes, reset values and timing counts.
package ppp_pkg;

    // Action select codes sampled on a load strobe
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;

    // Command byte codes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE_LOCK = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

    // Reset values of the nonvolatile bytes (all erased)
    localparam logic [7:0] FUSE_LO_RST = 8'hff;
    localparam logic [7:0] FUSE_HI_RST = 8'hff;
    localparam logic [7:0] FUSE_EXT_RST = 8'hff;
    localparam logic [7:0] LOCK_RST = 8'hff;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Lock byte layout
    localparam int LOCK_ONE_BIT = 0;
    localparam int LOCK_TWO_BIT = 1;
    localparam logic [7:0] LOCK_BOOT_MASK = 8'h3c;

    // Highest signature address
    localparam logic [7:0] SIG_ADDR_MAX = 8'h02;

    // Timing: clock period and busy windows
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_WLRL_MAX_NS = 1000;
    localparam int T_WLRH_MIN_NS = 3700000;
    localparam int T_WLRH_MAX_NS = 4500000;
    localparam int T_WLRH_CE_MIN_NS = 7500000;
    localparam int T_WLRH_CE_MAX_NS = 9000000;
    localparam int WLRL_MAX_CYC = T_WLRL_MAX_NS / CLK_PERIOD_NS;
    localparam int WR_BUSY_CYC =
        (T_WLRH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_BUSY_CYC =
        (T_WLRH_CE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_CNT_W = 21;

endpackage

// file: ppp_sync.sv
// Purpose: Two-stage synchroniser for the programming pins.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: First stage is read only by the second stage.
`timescale 1ns/100ps
`default_nettype none
module ppp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Pins in, synchronised out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Two flip-flops in series
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else if (ce_i) begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;

endmodule
`default_nettype wire

// file: ppp_busy_timer.sv
// Purpose: Self-timed busy window for write and erase operations.
// Assumes: Start pulses arrive only while idle.
// Notes: Counts enabled clock cycles down to zero.
`timescale 1ns/100ps
`default_nettype none
module ppp_busy_timer
    import ppp_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Start and length
    input wire logic start_i,
    input wire logic [BUSY_CNT_W-1:0] len_i,
    // Busy level
    output logic busy_o
);

    logic [BUSY_CNT_W-1:0] cnt_q;

    // Load on start, count down while busy
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (ce_i) begin
            if (start_i) begin
                cnt_q <= len_i;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    assign busy_o = (cnt_q != '0);

endmodule
`default_nettype wire

// file: ppp_port.sv
// Purpose: Device side of the high-voltage parallel programming port.
// Assumes: Programming mode already entered; memory arrays sit outside.
// Notes: All pins are synchronised; busy windows are self-timed.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Load strobe with action 00 address, 01 data, 10 command, 11 nothing.
// - Status output low while busy, high when ready for a command.
// - Keep last command and address after an operation for reuse.
// - All-zero command is a no-op clearing internal write enables.
// - EEPROM page: command, address high, then low, data, page latch.
// - Write pulse with low byte select 0 starts EEPROM page program.
// - Flash read gives low byte on select 0, high byte on select 1.
// - EEPROM read gives addressed byte with output enable low, select 0.
// - Data bus driven only while output enable is low.
// - Fuse write: low fuse byte takes data, zero programs a fuse.
// - Fuse write with selects low=1, high=0 writes fuse high byte.
// - Fuse write with selects low=0, high=1 writes extended fuse.
// - Lock write programs zero bits; mode 3 protects boot lock bits.
// - Lock bits clear only through chip erase.
// - Fuse/lock read selects byte by both byte-select inputs.
// - Signature read outputs identification byte for address 0 to 2.
// - Signature read, address 0, select 1 outputs calibration byte.
// - Status goes low within 1 us of write pulse fall.
// - Writes return ready between 3.7 and 4.5 ms after write.
// - Chip erase returns ready between 7.5 and 9 ms.
module ppp_port
    import ppp_pkg::*;
#(
    parameter int WR_CYC = WR_BUSY_CYC,
    parameter int ERASE_CYC = ERASE_BUSY_CYC,
    parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h0f  // Arbitrary value
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Programming pins
    input wire logic load_strobe_i,
    input wire logic action_select_hi_i,
    input wire logic action_select_lo_i,
    input wire logic byte_select_low_i,
    input wire logic byte_select_high_i,
    input wire logic page_latch_strobe_i,
    input wire logic wr_n_i,
    input wire logic oe_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic prog_status_out_o,
    // Memory array side
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    output logic page_load_o,
    output logic flash_prog_o,
    output logic eeprom_prog_o,
    output logic chip_erase_o,
    input wire logic [15:0] flash_rdata_i,
    input wire logic [7:0] eeprom_rdata_i,
    input wire logic [7:0] calib_i
);

    // Commands that start a self-timed operation
    function automatic logic is_write(input logic [7:0] c);
        return (c == CMD_CHIP_ERASE) || (c == CMD_WR_FUSE) ||
               (c == CMD_WR_LOCK) || (c == CMD_WR_FLASH) ||
               (c == CMD_WR_EEPROM);
    endfunction

    // Strobes idle low, write and output enable idle high
    localparam logic [15:0] SYNC_RST = 16'h00c0;

    logic [15:0] pins_s;
    logic ls_s, xa_lo_s, xa_hi_s, bs_lo_s, bs_hi_s, pl_s, wr_n_s, oe_n_s;
    logic [7:0] data_s;
    logic ls_q, pl_q, wr_n_q;
    logic [7:0] cmd_q, addr_lo_q, addr_hi_q, dat_lo_q, dat_hi_q;
    logic [7:0] fuse_lo_q, fuse_hi_q, fuse_ext_q, lock_q;
    logic load_en_q, busy;
    logic [7:0] rd_q, rd_d;
    logic page_load_q, flash_prog_q, eeprom_prog_q, chip_erase_q;

    // Pin synchroniser: all pins pass two flip-flops
    ppp_sync #(
        .W(16),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .d_i({data_i, oe_n_i, wr_n_i, page_latch_strobe_i,
              byte_select_high_i, byte_select_low_i, action_select_hi_i,
              action_select_lo_i, load_strobe_i}),
        .q_o(pins_s)
    );

    assign ls_s = pins_s[0];
    assign xa_lo_s = pins_s[1];
    assign xa_hi_s = pins_s[2];
    assign bs_lo_s = pins_s[3];
    assign bs_hi_s = pins_s[4];
    assign pl_s = pins_s[5];
    assign wr_n_s = pins_s[6];
    assign oe_n_s = pins_s[7];
    assign data_s = pins_s[15:8];

    // Edge detection and decode
    wire [1:0] act = {xa_hi_s, xa_lo_s};
    wire ls_rise = ce_i && ls_s && !ls_q;
    wire pl_rise = ce_i && pl_s && !pl_q;
    wire wr_fall = ce_i && !wr_n_s && wr_n_q;
    wire ld_cmd = ls_rise && (act == ACT_CMD);
    wire ld_addr = ls_rise && (act == ACT_ADDR);
    wire ld_data = ls_rise && (act == ACT_DATA);
    // Refused page writes must not open a busy window
    wire page_cmd = (cmd_q == CMD_WR_FLASH) || (cmd_q == CMD_WR_EEPROM);
    wire page_skip = page_cmd && (!load_en_q ||
                     ((cmd_q == CMD_WR_EEPROM) && bs_lo_s));
    wire start = wr_fall && !busy && is_write(cmd_q) && !page_skip;
    wire erase_go = start && (cmd_q == CMD_CHIP_ERASE);
    wire fuse_go = start && (cmd_q == CMD_WR_FUSE);
    wire lock_go = start && (cmd_q == CMD_WR_LOCK);
    wire flash_go = start && (cmd_q == CMD_WR_FLASH) && load_en_q;
    wire eep_go = start && (cmd_q == CMD_WR_EEPROM) && load_en_q &&
                  !bs_lo_s;
    wire mode3 = !lock_q[LOCK_ONE_BIT] && !lock_q[LOCK_TWO_BIT];
    wire [7:0] lock_keep = mode3 ? LOCK_BOOT_MASK : 8'h00;
    wire [BUSY_CNT_W-1:0] busy_len = erase_go ?
        BUSY_CNT_W'(ERASE_CYC) : BUSY_CNT_W'(WR_CYC);

    // Edge history
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ls_q <= 1'b0;
            pl_q <= 1'b0;
            wr_n_q <= 1'b1;
        end else if (ce_i) begin
            ls_q <= ls_s;
            pl_q <= pl_s;
            wr_n_q <= wr_n_s;
        end
    end

    // Command, address and data holding registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmd_q <= CMD_NOP;
            addr_lo_q <= 8'h00;
            addr_hi_q <= 8'h00;
            dat_lo_q <= 8'h00;
            dat_hi_q <= 8'h00;
        end else begin
            if (ld_cmd) begin
                cmd_q <= data_s;
            end
            if (ld_addr && !bs_lo_s) begin
                addr_lo_q <= data_s;
            end
            if (ld_addr && bs_lo_s) begin
                addr_hi_q <= data_s;
            end
            if (ld_data && !bs_lo_s) begin
                dat_lo_q <= data_s;
            end
            if (ld_data && bs_lo_s) begin
                dat_hi_q <= data_s;
            end
        end
    end

    // Page-load enable set by flash and EEPROM write commands, cleared by any other command
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            load_en_q <= 1'b0;
        end else if (ld_cmd) begin
            load_en_q <= (data_s == CMD_WR_FLASH) ||
                         (data_s == CMD_WR_EEPROM);
        end
    end

    // Fuse bytes: each bit takes the data bit, zero programs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fuse_lo_q <= FUSE_LO_RST;
            fuse_hi_q <= FUSE_HI_RST;
            fuse_ext_q <= FUSE_EXT_RST;
        end else if (fuse_go) begin
            if (!bs_lo_s && !bs_hi_s) begin
                fuse_lo_q <= dat_lo_q;
            end else if (bs_lo_s && !bs_hi_s) begin
                fuse_hi_q <= dat_lo_q;
            end else if (!bs_lo_s && bs_hi_s) begin
                fuse_ext_q <= dat_lo_q;
            end
        end
    end

    // Lock bits: program only, clear only by chip erase
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            lock_q <= LOCK_RST;
        end else if (erase_go) begin
            lock_q <= ERASED_BYTE;
        end else if (lock_go) begin
            lock_q <= lock_q & (dat_lo_q | lock_keep);
        end
    end

    // Memory side strobes, one cycle each
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            page_load_q <= 1'b0;
            flash_prog_q <= 1'b0;
            eeprom_prog_q <= 1'b0;
            chip_erase_q <= 1'b0;
        end else if (ce_i) begin
            page_load_q <= pl_rise && load_en_q;
            flash_prog_q <= flash_go;
            eeprom_prog_q <= eep_go;
            chip_erase_q <= erase_go;
        end
    end

    // Busy window timer
    ppp_busy_timer u_timer (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .start_i(start),
        .len_i(busy_len),
        .busy_o(busy)
    );

    // Read data selection by command and byte selects
    always_comb begin
        rd_d = ERASED_BYTE;
        case (cmd_q)
            CMD_RD_FLASH: begin
                rd_d = bs_lo_s ? flash_rdata_i[15:8]
                               : flash_rdata_i[7:0];
            end
            CMD_RD_EEPROM: begin
                rd_d = eeprom_rdata_i;
            end
            CMD_RD_FUSE_LOCK: begin
                case ({bs_hi_s, bs_lo_s})
                    2'h0: rd_d = fuse_lo_q;
                    2'h3: rd_d = fuse_hi_q;
                    2'h2: rd_d = fuse_ext_q;
                    default: rd_d = lock_q;
                endcase
            end
            CMD_RD_SIG: begin
                if (bs_lo_s) begin
                    rd_d = calib_i;
                end else if (addr_lo_q == 8'h00) begin
                    rd_d = SIG_BYTE0;
                end else if (addr_lo_q == 8'h01) begin
                    rd_d = SIG_BYTE1;
                end else if (addr_lo_q == SIG_ADDR_MAX) begin
                    rd_d = SIG_BYTE2;
                end
            end
            default: begin
                rd_d = ERASED_BYTE;
            end
        endcase
    end

    // Registered read data
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_q <= ERASED_BYTE;
        end else if (ce_i) begin
            rd_q <= rd_d;
        end
    end

    // Outputs
    assign data_o = rd_q;
    assign data_oe_o = !oe_n_s;
    assign prog_status_out_o = !busy;
    assign mem_addr_o = {addr_hi_q, addr_lo_q};
    assign mem_wdata_o = {dat_hi_q, dat_lo_q};
    assign page_load_o = page_load_q;
    assign flash_prog_o = flash_prog_q;
    assign eeprom_prog_o = eeprom_prog_q;
    assign chip_erase_o = chip_erase_q;

    // Helper: enabled cycles since start, and kind of operation
    logic [BUSY_CNT_W-1:0] busy_cyc_h;
    logic erase_h;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_cyc_h <= '0;
            erase_h <= 1'b0;
        end else if (ce_i) begin
            busy_cyc_h <= start ? '0 : busy_cyc_h + 1'b1;
            erase_h <= start ? erase_go : erase_h;
        end
    end

    // Status falls right after an accepted write pulse
    status_fall_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        start |=> !prog_status_out_o)
        else $error("status not low after write pulse");

    // Write busy window length
    write_window_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($rose(prog_status_out_o) && !erase_h) |->
        (busy_cyc_h == BUSY_CNT_W'(WR_CYC)))
        else $error("write busy window wrong length");

    // Erase busy window length
    erase_window_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ($rose(prog_status_out_o) && erase_h) |->
        (busy_cyc_h == BUSY_CNT_W'(ERASE_CYC)))
        else $error("erase busy window wrong length");

    // Bus released after output enable stays high
    bus_release_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (oe_n_i && ce_i)[*3] |-> !data_oe_o)
        else $error("data bus driven with output enable high");

    // Command capture on strobe
    cmd_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ld_cmd |=> (cmd_q == $past(data_s)))
        else $error("command byte not captured");

    // Command kept without a new command load
    cmd_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !ld_cmd |=> $stable(cmd_q))
        else $error("command changed without load");

    // No-op clears page-load enable
    nop_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ld_cmd && (data_s == CMD_NOP)) |=> !load_en_q)
        else $error("no-op did not clear write enable");

    // Lock bits never return to one without erase
    lock_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !erase_go |=> ((lock_q & ~$past(lock_q)) == 8'h00))
        else $error("lock bit cleared without chip erase");

    // Boot lock bits frozen in mode 3
    boot_lock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (lock_go && mode3) |=>
        ((lock_q & LOCK_BOOT_MASK) == ($past(lock_q) & LOCK_BOOT_MASK)))
        else $error("boot lock bits changed in mode 3");

    // Flash low byte presented
    flash_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && (cmd_q == CMD_RD_FLASH) && !bs_lo_s) |=>
        (data_o == $past(flash_rdata_i[7:0])))
        else $error("flash low byte not presented");

endmodule
`default_nettype wire

// file: ppp_prog_model.sv
// Purpose: Programmer model for the parallel programming port.
// Assumes: Pins move 1 ns after a rising clock edge.
// Notes: Pins are held 4 clocks around every strobe and pulse.
`timescale 1ns/100ps
`default_nettype none
module ppp_prog_model (
    // Clock and status in
    input wire logic clk_i,
    input wire logic status_i,
    // Pins to the device
    output logic strobe_o,
    output logic [1:0] act_o,
    output logic bs_lo_o,
    output logic bs_hi_o,
    output logic pgl_o,
    output logic wr_n_o,
    output logic oe_n_o,
    output logic [7:0] d_o
);
    // Idle levels at time zero
    initial begin
        {strobe_o, pgl_o, bs_lo_o, bs_hi_o} = 4'h0;
        {wr_n_o, oe_n_o} = 2'h3;
        act_o = 2'h3;
        d_o = 8'h00;
    end

    // Wait n edges, then move off the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // One strobe load; bus shows the inverse once released
    task automatic load(input logic [1:0] a, input logic s,
                        input logic [7:0] b);
        act_o = a;
        bs_lo_o = s;
        d_o = b;
        step(4);
        strobe_o = 1'b1;
        step(4);
        strobe_o = 1'b0;
        step(4);
        act_o = 2'h3;
        bs_lo_o = 1'b0;
        d_o = ~b;
        step(1);
    endtask

    // Page latch pulse with the high byte selected
    task automatic latch();
        bs_lo_o = 1'b1;
        step(4);
        pgl_o = 1'b1;
        step(4);
        pgl_o = 1'b0;
        step(4);
        bs_lo_o = 1'b0;
        step(1);
    endtask

    // Write pulse, then wait for ready before anything else
    task automatic write(input logic hi, lo);
        bs_hi_o = hi;
        bs_lo_o = lo;
        step(4);
        wr_n_o = 1'b0;
        step(4);
        wr_n_o = 1'b1;
        for (int i = 0; i < 400 && !status_i; i++) begin
            step(1);
        end
        bs_hi_o = 1'b0;
        bs_lo_o = 1'b0;
        step(4);
    endtask

    // Output enable low with byte selects set
    task automatic read(input logic hi, lo);
        bs_hi_o = hi;
        bs_lo_o = lo;
        oe_n_o = 1'b0;
        step(6);
    endtask

    // Output enable high, selects back to the low byte
    task automatic read_end();
        oe_n_o = 1'b1;
        bs_hi_o = 1'b0;
        bs_lo_o = 1'b0;
        step(6);
    endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Purpose: Self-checking bench for the parallel programming port.
// Assumes: Busy windows shortened to 20 and 40 clocks.
// Notes: Memory arrays are modelled as functions of the address.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top
    import ppp_pkg::*;
;
    localparam int WR_C = 20;
    localparam int ER_C = 40;
    localparam logic [7:0] CALIB = 8'h96; // Arbitrary value
    localparam logic [7:0] SIG [3] = '{8'hc1, 8'h27, 8'h9e}; // Arbitrary
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic strobe, bs_lo, bs_hi, pgl, wr_n, oe_n, status, data_oe;
    logic ppl, fpr, epr, cer;
    logic [1:0] act;
    logic [7:0] pd, bus, data_o, erd, rv;
    logic [15:0] addr, frd, a, e, wd;
    logic [7:0] fv [3];
    logic [31:0] seed = 32'ha0d1ced0;
    int n_errors = 0, n_tests = 0, n_pl = 0, n_fp = 0, n_ep = 0, n_ce = 0;
    int since_wr = 0, lat_lo = 0, lat_hi = 0, n_bf = 0;

    // Expected memory contents for an address
    function automatic logic [15:0] fexp(input logic [15:0] v);
        return {v[7:0], v[15:8]} ^ 16'h5aa5;
    endfunction
    function automatic logic [7:0] eexp(input logic [15:0] v);
        return v[7:0] ^ v[15:8] ^ 8'h3c;
    endfunction

    // Memory arrays and the shared data wire
    assign frd = {addr[7:0], addr[15:8]} ^ 16'h5aa5;
    assign erd = addr[7:0] ^ addr[15:8] ^ 8'h3c;
    assign bus = data_oe ? data_o : pd;

    initial forever #2 clk_i = ~clk_i;

    ppp_prog_model ppp_prog_model_i (.clk_i(clk_i), .status_i(status),
        .strobe_o(strobe), .act_o(act), .bs_lo_o(bs_lo), .bs_hi_o(bs_hi),
        .pgl_o(pgl), .wr_n_o(wr_n), .oe_n_o(oe_n), .d_o(pd));

    ppp_port #(.WR_CYC(WR_C), .ERASE_CYC(ER_C), .SIG_BYTE0(SIG[0]),
        .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2])) ppp_port_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .load_strobe_i(strobe), .action_select_hi_i(act[1]),
        .action_select_lo_i(act[0]), .byte_select_low_i(bs_lo),
        .byte_select_high_i(bs_hi), .page_latch_strobe_i(pgl),
        .wr_n_i(wr_n), .oe_n_i(oe_n), .data_i(bus), .data_o(data_o),
        .data_oe_o(data_oe), .prog_status_out_o(status),
        .mem_addr_o(addr), .mem_wdata_o(wd), .page_load_o(ppl),
        .flash_prog_o(fpr), .eeprom_prog_o(epr), .chip_erase_o(cer),
        .flash_rdata_i(frd), .eeprom_rdata_i(erd), .calib_i(CALIB));

    // Pulse counters and busy timing from the write pulse fall
    always @(posedge clk_i) begin
        n_pl += ppl;
        n_fp += fpr;
        n_ep += epr;
        n_ce += cer;
        since_wr++;
    end
    always @(negedge wr_n) since_wr = 0;
    always @(negedge status) begin
        lat_lo = since_wr;
        n_bf++;
    end
    always @(posedge status) lat_hi = since_wr;

    // Short forms of the programmer steps
    task automatic cmd(input logic [7:0] b);
        ppp_prog_model_i.load(ACT_CMD, 1'b0, b);
    endtask
    task automatic dat(input logic [7:0] b);
        ppp_prog_model_i.load(ACT_DATA, 1'b0, b);
    endtask
    task automatic adr(input logic [15:0] v);
        ppp_prog_model_i.load(ACT_ADDR, 1'b1, v[15:8]);
        ppp_prog_model_i.load(ACT_ADDR, 1'b0, v[7:0]);
    endtask

    // Write pulse with busy window checks
    task automatic wr(input logic hi, lo, input int cyc);
        ppp_prog_model_i.write(hi, lo);
        `CHK("busy_low", 1'b1, lat_lo <= WLRL_MAX_CYC)
        `CHK("busy_len", 1'b1, lat_hi >= cyc && lat_hi <= cyc + 8)
    endtask

    // Read one byte from the wire, then release
    task automatic rd(input logic hi, lo, input logic [7:0] x);
        ppp_prog_model_i.read(hi, lo);
        `CHK("drive", 1'b1, data_oe)
        `CHK("rdata", x, bus)
        ppp_prog_model_i.read_end();
        `CHK("release", 1'b0, data_oe)
    endtask

    // Counts before the verdict
    task automatic wrap_up();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        `CHK("ready", 1'b1, status)
        `CHK("oe_rst", 1'b0, data_oe)
        for (int k = 0; k < 3; k++) begin
            fv[k] = 8'($random(seed));
            cmd(CMD_WR_FUSE);
            dat(fv[k]);
            wr(k == 2, k == 1, WR_C);
        end
        cmd(CMD_RD_FUSE_LOCK);
        rd(1'b0, 1'b0, fv[0]);
        rd(1'b1, 1'b1, fv[1]);
        rd(1'b1, 1'b0, fv[2]);
        // Mode 3 first, then boot bits must hold
        cmd(CMD_WR_LOCK);
        dat(8'hfc);
        wr(1'b0, 1'b0, WR_C);
        dat(8'h03);
        wr(1'b0, 1'b0, WR_C);
        cmd(CMD_RD_FUSE_LOCK);
        rd(1'b0, 1'b1, 8'h3c);
        cmd(CMD_CHIP_ERASE);
        wr(1'b0, 1'b0, ER_C);
        `CHK("erase", 1, n_ce)
        cmd(CMD_RD_FUSE_LOCK);
        rd(1'b0, 1'b1, LOCK_RST);
        rd(1'b0, 1'b0, fv[0]);
        // Flash page, then an EEPROM page of two bytes
        cmd(CMD_WR_FLASH);
        adr(16'h0140);
        dat(8'h3b);
        ppp_prog_model_i.load(ACT_DATA, 1'b1, 8'hc4);
        `CHK("wdata", 16'hc43b, wd)
        ppp_prog_model_i.latch();
        wr(1'b0, 1'b0, WR_C);
        `CHK("flash_prog", 1, n_fp)
        cmd(CMD_WR_EEPROM);
        ppp_prog_model_i.load(ACT_ADDR, 1'b1, 8'h02);
        for (int j = 0; j < 2; j++) begin
            ppp_prog_model_i.load(ACT_ADDR, 1'b0, j[7:0]);
            rv = 8'($random(seed));
            dat(rv);
            `CHK("wdata_lo", rv, wd[7:0])
            ppp_prog_model_i.latch();
        end
        `CHK("page_load", 3, n_pl)
        ppp_prog_model_i.write(1'b0, 1'b1);
        `CHK("ee_sel", 0, n_ep)
        `CHK("ee_sel_busy", 7, n_bf)
        wr(1'b0, 1'b0, WR_C);
        `CHK("ee_prog", 1, n_ep)
        // No-op ends the session; latch and write then do nothing
        cmd(CMD_NOP);
        ppp_prog_model_i.latch();
        ppp_prog_model_i.write(1'b0, 1'b0);
        `CHK("nop_latch", 3, n_pl)
        `CHK("nop_write", 1, n_ep)
        `CHK("nop_ready", 1'b1, status)
        `CHK("nop_busy", 8, n_bf)
        // Flash reads, an idle action, then reuse of the address
        for (int k = 0; k < 3; k++) begin
            a = (k == 0) ? 16'hffff : 16'($random(seed));
            e = fexp(a);
            cmd(CMD_RD_FLASH);
            adr(a);
            `CHK("addr", a, addr)
            ppp_prog_model_i.load(ACT_IDLE, 1'b0, ~a[7:0]);
            `CHK("idle", a, addr)
            rd(1'b0, 1'b0, e[7:0]);
            rd(1'b0, 1'b1, e[15:8]);
        end
        cmd(CMD_RD_EEPROM);
        rd(1'b0, 1'b0, eexp(a));
        cmd(CMD_RD_SIG);
        for (int k = 0; k < 4; k++) begin
            ppp_prog_model_i.load(ACT_ADDR, 1'b0, k[7:0]);
            rd(1'b0, 1'b0, (k < 3) ? SIG[k] : ERASED_BYTE);
        end
        ppp_prog_model_i.load(ACT_ADDR, 1'b0, 8'h00);
        rd(1'b0, 1'b1, CALIB);
        wrap_up();
    end
endmodule
`default_nettype wire
